// ===== core/pmx_mode_mux.sv
// Automatic level selection, blanking signal, edge synthesis and output combiner.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Up to two extra levels switch automatically
// - Duty value picks base, mid or high set
// - Four thresholds form per-transition hysteresis pairs
// - Base to mid above upper, back below lower
// - Blanking signal high from window start to end
// - Synth uses own and next engine, wrapping
// - Four edges each pick one of eight sources
// - Codes 0-3 own events, 4-7 next engine
// - Cleared synth enable contributes no edges
// - Combiner selection follows active configuration set
// - Combiner disabled passes normal engine outputs
// - Combiner on forces coarse edge placement
// - Output A combiner code selects listed sources
// - Neighbour engine indices wrap modulo four
// - Overcurrent during output A ends pulse immediately
// - Option matches B width to truncated A
module pmx_mode_mux #(
  parameter int ENGINES = pmx_pkg::ENGINE_COUNT,
  parameter int DW = pmx_pkg::DUTY_WIDTH,
  parameter int CW = pmx_pkg::COUNT_WIDTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Loop filter duty and level switching controls
  input wire logic [DW-1:0] filter_duty,
  input wire logic auto_en,
  input wire logic [1:0] levels_used,
  input wire pmx_pkg::pmx_thresh_type thresh,
  // Configuration sets per engine
  input wire pmx_pkg::pmx_cfg_type [ENGINES-1:0] base_level_config,
  input wire pmx_pkg::pmx_cfg_type [ENGINES-1:0] mid_level_config,
  input wire pmx_pkg::pmx_cfg_type [ENGINES-1:0] high_level_config,
  input wire pmx_pkg::pmx_edge_ctl_type [ENGINES-1:0] edge_synth_control,
  // Engine waveforms and blanking window times
  input wire logic [CW-1:0] pwm_count [ENGINES],
  input wire logic [CW-1:0] blank_start [ENGINES],
  input wire logic [CW-1:0] blank_end [ENGINES],
  input wire logic [ENGINES-1:0] raw_a,
  input wire logic [ENGINES-1:0] raw_b,
  // Current comparator pin
  input wire logic [ENGINES-1:0] current_trip_pin,
  // Gate drive outputs and status
  output logic [ENGINES-1:0] pwm_out_a,
  output logic [ENGINES-1:0] pwm_out_b,
  output logic [2:0] active_level,
  output logic [ENGINES-1:0] coarse_mode,
  output logic [ENGINES-1:0] limit_event
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Neighbour index wrapping modulo the engine count
  function automatic int wrap_idx(input int n, input int off);
    return (n + off) % ENGINES;
  endfunction

  // ****************************************************************
  // Automatic level selection
  // ****************************************************************
  pmx_pkg::pmx_level_type level_q;
  pmx_pkg::pmx_level_type level_d;

  // Hysteretic next level; each boundary uses its own pair
  always_comb begin
    level_d = level_q;
    unique case (level_q)
      pmx_pkg::PMX_LVL_BASE: begin
        // Leave base only above the low-pair upper threshold
        if (levels_used != 2'h0 && filter_duty > thresh.low_upper) begin
          level_d = pmx_pkg::PMX_LVL_MID;
        end
      end
      pmx_pkg::PMX_LVL_MID: begin
        // Return to base only below the low-pair lower threshold
        if (filter_duty < thresh.low_lower) begin
          level_d = pmx_pkg::PMX_LVL_BASE;
        end else if (levels_used == 2'h2 && filter_duty > thresh.high_upper) begin
          level_d = pmx_pkg::PMX_LVL_HIGH;
        end
      end
      pmx_pkg::PMX_LVL_HIGH: begin
        // High pair gives the same hysteresis one step up
        if (filter_duty < thresh.high_lower) begin
          level_d = pmx_pkg::PMX_LVL_MID;
        end
      end
      default: begin
        // Illegal code recovers to base
        level_d = pmx_pkg::PMX_LVL_BASE;
      end
    endcase
  end

  // Level register; no software action needed to move
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      level_q <= pmx_pkg::PMX_LVL_BASE;
    end else if (!auto_en) begin
      // Without automatic switching the base set governs
      level_q <= pmx_pkg::PMX_LVL_BASE;
    end else begin
      level_q <= level_d;
    end
  end

  assign active_level = level_q;

  // ****************************************************************
  // Current trip synchroniser
  // ****************************************************************
  logic [ENGINES-1:0] trip_s1_q; // First stage, read only by the second
  logic [ENGINES-1:0] trip_s2_q;
  logic [ENGINES-1:0] trip_s3_q;
  logic [ENGINES-1:0] trip_q; // Accepted level, changes when s2 and s3 agree

  // Three stages plus an agreement flop; the comparator is asynchronous to this clock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trip_s1_q <= '0;
      trip_s2_q <= '0;
      trip_s3_q <= '0;
      trip_q <= '0;
    end else begin
      trip_s1_q <= current_trip_pin;
      trip_s2_q <= trip_s1_q;
      trip_s3_q <= trip_s2_q;
      trip_q <= (trip_s2_q & trip_s3_q) | (trip_q & (trip_s2_q | trip_s3_q));
    end
  end

  // ****************************************************************
  // Per-engine logic
  // ****************************************************************
  logic [ENGINES-1:0] blank_q; // Internal blanking window signal
  logic [ENGINES-1:0] a_trunc; // Output A after cycle-by-cycle limit
  logic [ENGINES-1:0] b_match; // Output B after width matching
  logic [ENGINES-1:0] synth_a;
  logic [ENGINES-1:0] synth_b;
  pmx_pkg::pmx_cfg_type cfg [ENGINES];

  genvar gi;
  generate
    for (gi = 0; gi < ENGINES; gi++) begin : g_eng
      localparam int N1 = wrap_idx(gi, 1);
      localparam int N2 = wrap_idx(gi, 2);
      localparam int N3 = wrap_idx(gi, 3);
      logic cut_q; // Pulse of A cut short in this cycle
      logic b_stop_q; // B held low after matched width ran out
      logic [CW-1:0] a_width_q; // Width of output A so far
      logic [CW-1:0] b_width_q; // Width of output B so far
      logic [CW-1:0] cut_width_q; // Truncated width of A
      logic [CW-1:0] coarse_cnt_q; // Coarse edge step timer
      logic coarse_tick;
      logic [3:0] sel_a;
      logic [3:0] sel_b;
      logic [8:0] src_a;
      logic [8:0] src_b;

      // Active configuration set follows the level, routing too
      always_comb begin
        unique case (level_q)
          pmx_pkg::PMX_LVL_MID: cfg[gi] = mid_level_config[gi];
          pmx_pkg::PMX_LVL_HIGH: cfg[gi] = high_level_config[gi];
          default: cfg[gi] = base_level_config[gi];
        endcase
      end

      // Blanking signal from window start to window end
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          blank_q[gi] <= 1'b0;
        end else if (pwm_count[gi] == blank_start[gi]) begin
          blank_q[gi] <= 1'b1;
        end else if (pwm_count[gi] == blank_end[gi]) begin
          blank_q[gi] <= 1'b0;
        end
      end

      // Cycle-by-cycle limit: trip while A conducts kills the pulse
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          cut_q <= 1'b0;
          a_width_q <= '0;
          cut_width_q <= '0;
        end else if (!raw_a[gi]) begin
          // Rearm at the end of the engine's A pulse
          cut_q <= 1'b0;
          a_width_q <= '0;
        end else begin
          if (!cut_q) begin
            a_width_q <= a_width_q + 1'b1;
          end
          if (trip_q[gi] && !cut_q) begin
            cut_q <= 1'b1;
            cut_width_q <= a_width_q;
          end
        end
      end

      // Combinational cut so the pulse ends in the trip cycle
      assign a_trunc[gi] = raw_a[gi] & ~cut_q & ~trip_q[gi];
      assign limit_event[gi] = raw_a[gi] & trip_q[gi] & ~cut_q;

      // Optional B width matching to the truncated A width
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          b_width_q <= '0;
          b_stop_q <= 1'b0;
        end else if (!raw_b[gi]) begin
          b_width_q <= '0;
          b_stop_q <= 1'b0;
        end else begin
          b_width_q <= b_width_q + 1'b1;
          if (cfg[gi].match_b && cut_width_q != '0 &&
              b_width_q + 1'b1 >= cut_width_q) begin
            b_stop_q <= 1'b1;
          end
        end
      end

      assign b_match[gi] = raw_b[gi] & ~b_stop_q;

      // Synthesizer takes own and next engine, last wraps to zero
      pmx_edge_synth u_synth (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .ctl(edge_synth_control[gi]),
        .own_a(a_trunc[gi]),
        .own_b(b_match[gi]),
        .nxt_a(a_trunc[N1]),
        .nxt_b(b_match[N1]),
        .synth_a(synth_a[gi]),
        .synth_b(synth_b[gi])
      );

      // Source vectors ordered by combiner code
      assign src_a = {blank_q[N3], blank_q[N2], blank_q[N1], b_match[N1],
                      a_trunc[N1], b_match[gi], blank_q[gi], synth_a[gi], a_trunc[gi]};
      assign src_b = {blank_q[N3], blank_q[N2], blank_q[N1], b_match[N1],
                      a_trunc[N1], a_trunc[gi], blank_q[gi], synth_b[gi], b_match[gi]};
      // Codes above the list fall back to pass through
      assign sel_a = (cfg[gi].mux_a > pmx_pkg::MUX_NXT3_BLANK) ? pmx_pkg::MUX_OWN : cfg[gi].mux_a;
      assign sel_b = (cfg[gi].mux_b > pmx_pkg::MUX_NXT3_BLANK) ? pmx_pkg::MUX_OWN : cfg[gi].mux_b;

      // Coarse step timer used while the combiner is on
      always_ff @(posedge sys_clk) begin
        if (sys_rst || !cfg[gi].comb_en) begin
          coarse_cnt_q <= '0;
        end else if (coarse_cnt_q == CW'(pmx_pkg::COARSE_STEP_CYC - 1)) begin
          coarse_cnt_q <= '0;
        end else begin
          coarse_cnt_q <= coarse_cnt_q + 1'b1;
        end
      end

      assign coarse_tick = (coarse_cnt_q == CW'(pmx_pkg::COARSE_STEP_CYC - 1));
      // Hires placement is ignored while the combiner is on
      assign coarse_mode[gi] = cfg[gi].comb_en;

      // Registered gate drive outputs
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          pwm_out_a[gi] <= 1'b0;
          pwm_out_b[gi] <= 1'b0;
        end else if (!cfg[gi].comb_en) begin
          // Combiner off: normal waveform drives the outputs
          pwm_out_a[gi] <= a_trunc[gi];
          pwm_out_b[gi] <= b_match[gi];
        end else if (coarse_tick) begin
          // Combiner on: edges land on the coarse grid only
          pwm_out_a[gi] <= src_a[sel_a];
          pwm_out_b[gi] <= src_b[sel_b];
        end
      end
    end
  endgenerate

endmodule // pmx_mode_mux
`default_nettype wire

// ===== core/pmx_pkg.sv
// Package with constants, codes and carrier types of the PWM mode switch and edge mux.
package pmx_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int ENGINE_COUNT = 4;
  localparam int DUTY_WIDTH = 16;
  localparam int COUNT_WIDTH = 16;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [3:0] MUX_CODE_RST = 4'h0;
  localparam logic [2:0] EDGE_CODE_RST = 3'h0;
  localparam logic [1:0] LEVEL_RST = 2'h1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 20000;
  localparam int COARSE_STEP_PS = 4000;
  // Coarse edge step in system clocks; never below one cycle
  localparam int COARSE_STEP_CYC =
    (COARSE_STEP_PS / CLK_PERIOD_PS) < 1 ? 1 : (COARSE_STEP_PS / CLK_PERIOD_PS);

  // ****************************************************************
  // Edge source codes
  // ****************************************************************
  localparam logic [2:0] EDGE_OWN_A_RISE = 3'h0;
  localparam logic [2:0] EDGE_OWN_A_FALL = 3'h1;
  localparam logic [2:0] EDGE_OWN_B_RISE = 3'h2;
  localparam logic [2:0] EDGE_OWN_B_FALL = 3'h3;
  localparam logic [2:0] EDGE_NXT_A_RISE = 3'h4;
  localparam logic [2:0] EDGE_NXT_A_FALL = 3'h5;
  localparam logic [2:0] EDGE_NXT_B_RISE = 3'h6;
  localparam logic [2:0] EDGE_NXT_B_FALL = 3'h7;

  // ****************************************************************
  // Output combiner codes
  // ****************************************************************
  localparam logic [3:0] MUX_OWN = 4'h0;
  localparam logic [3:0] MUX_SYNTH = 4'h1;
  localparam logic [3:0] MUX_BLANK = 4'h2;
  localparam logic [3:0] MUX_CROSS = 4'h3;
  localparam logic [3:0] MUX_NXT1_A = 4'h4;
  localparam logic [3:0] MUX_NXT1_B = 4'h5;
  localparam logic [3:0] MUX_NXT1_BLANK = 4'h6;
  localparam logic [3:0] MUX_NXT2_BLANK = 4'h7;
  localparam logic [3:0] MUX_NXT3_BLANK = 4'h8;

  // ****************************************************************
  // Types
  // ****************************************************************
  // One-hot configuration level
  typedef enum logic [2:0] {
    PMX_LVL_BASE = 3'h1,
    PMX_LVL_MID = 3'h2,
    PMX_LVL_HIGH = 3'h4
  } pmx_level_type;

  // Per-engine configuration set (one of base, mid, high)
  typedef struct packed {
    logic comb_en;
    logic [3:0] mux_a;
    logic [3:0] mux_b;
    logic hires_en;
    logic match_b;
  } pmx_cfg_type;

  // Edge synthesizer control, one per engine
  typedef struct packed {
    logic en;
    logic [2:0] a_rise;
    logic [2:0] a_fall;
    logic [2:0] b_rise;
    logic [2:0] b_fall;
  } pmx_edge_ctl_type;

  // Four hysteresis thresholds
  typedef struct packed {
    logic [DUTY_WIDTH-1:0] low_lower;
    logic [DUTY_WIDTH-1:0] low_upper;
    logic [DUTY_WIDTH-1:0] high_lower;
    logic [DUTY_WIDTH-1:0] high_upper;
  } pmx_thresh_type;

endpackage

// ===== core/pmx_edge_synth.sv
// Edge synthesizer building two outputs from edges of its own and the next engine.
`timescale 1ns/100ps
`default_nettype none
module pmx_edge_synth (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control
  input wire pmx_pkg::pmx_edge_ctl_type ctl,
  // Engine outputs after limit and B matching, own then next
  input wire logic own_a,
  input wire logic own_b,
  input wire logic nxt_a,
  input wire logic nxt_b,
  // Synthesized outputs
  output logic synth_a,
  output logic synth_b
);

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  logic [3:0] prev_q; // Previous levels of own A, own B, next A, next B
  logic [7:0] evt; // Eight source events in code order

  // Remember last level to spot edges
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prev_q <= 4'h0;
    end else begin
      prev_q <= {nxt_b, nxt_a, own_b, own_a};
    end
  end

  // Events indexed by source code
  always_comb begin
    evt[0] = own_a & ~prev_q[0];
    evt[1] = ~own_a & prev_q[0];
    evt[2] = own_b & ~prev_q[1];
    evt[3] = ~own_b & prev_q[1];
    evt[4] = nxt_a & ~prev_q[2];
    evt[5] = ~nxt_a & prev_q[2];
    evt[6] = nxt_b & ~prev_q[3];
    evt[7] = ~nxt_b & prev_q[3];
  end

  // ****************************************************************
  // Output latches
  // ****************************************************************
  // Each edge has its own selector; rise wins if both fire at once
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      synth_a <= 1'b0;
      synth_b <= 1'b0;
    end else if (!ctl.en) begin
      // Disabled synthesizer contributes no edges
      synth_a <= 1'b0;
      synth_b <= 1'b0;
    end else begin
      if (evt[ctl.a_rise]) begin
        synth_a <= 1'b1;
      end else if (evt[ctl.a_fall]) begin
        synth_a <= 1'b0;
      end
      if (evt[ctl.b_rise]) begin
        synth_b <= 1'b1;
      end else if (evt[ctl.b_fall]) begin
        synth_b <= 1'b0;
      end
    end
  end

endmodule // pmx_edge_synth
`default_nettype wire

// ===== tb/pmx_mode_mux_sva.sv
// Checker of level switching, combiner enables and pulse cutting.
`timescale 1ns/100ps
`default_nettype none
module pmx_mode_mux_chk #(
  parameter int ENGINES = 4,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Level switching inputs
  input wire logic [DW-1:0] filter_duty,
  input wire logic auto_en,
  input wire logic [1:0] levels_used,
  input wire pmx_pkg::pmx_thresh_type thresh,
  // Configuration sets
  input wire pmx_pkg::pmx_cfg_type [ENGINES-1:0] base_level_config,
  input wire pmx_pkg::pmx_cfg_type [ENGINES-1:0] mid_level_config,
  input wire pmx_pkg::pmx_cfg_type [ENGINES-1:0] high_level_config,
  // Waveforms and status
  input wire logic [ENGINES-1:0] raw_a,
  input wire logic [ENGINES-1:0] pwm_out_a,
  input wire logic [2:0] active_level,
  input wire logic [ENGINES-1:0] coarse_mode,
  input wire logic [ENGINES-1:0] limit_event
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Expected combiner enable, taken from whichever set is active
  logic [ENGINES-1:0] comb_exp;
  always_comb begin
    for (int i = 0; i < ENGINES; i++) begin
      comb_exp[i] = active_level[2] ? high_level_config[i].comb_en :
        active_level[1] ? mid_level_config[i].comb_en : base_level_config[i].comb_en;
    end
  end
  a_level_onehot: assert property ($onehot(active_level))
    else $error("level not one-hot");
  a_base_to_mid: assert property (active_level == 3'h1 && auto_en && levels_used != 2'h0
    && filter_duty > thresh.low_upper |=> active_level == 3'h2) else $error("no rise to mid");
  a_base_hold: assert property (active_level == 3'h1 && filter_duty <= thresh.low_upper
    |=> active_level == 3'h1) else $error("base left early");
  a_mid_hold: assert property (active_level == 3'h2 && auto_en
    && filter_duty >= thresh.low_lower && !(levels_used == 2'h2 && filter_duty > thresh.high_upper)
    |=> active_level == 3'h2) else $error("mid left inside band");
  a_auto_off: assert property (!auto_en |=> active_level == 3'h1)
    else $error("not base with switching off");
  a_mid_to_high: assert property (active_level == 3'h2 && auto_en && levels_used == 2'h2
    && filter_duty > thresh.high_upper |=> active_level == 3'h4) else $error("no rise to high");
  a_high_to_mid: assert property (active_level == 3'h4 && auto_en
    && filter_duty < thresh.high_lower |=> active_level == 3'h2) else $error("no drop to mid");
  a_coarse_set: assert property (coarse_mode == comb_exp)
    else $error("coarse flag not from active set");
  a_trip_cut: assert property (limit_event[0] && !coarse_mode[0] |=> !pwm_out_a[0])
    else $error("pulse not cut after trip");
  a_off_low: assert property (!coarse_mode[0] && !raw_a[0] |=> !pwm_out_a[0])
    else $error("output high without engine pulse");
endmodule // pmx_mode_mux_chk
bind pmx_mode_mux pmx_mode_mux_chk #(.ENGINES(ENGINES), .DW(DW)) pmx_mode_mux_chk_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .filter_duty(filter_duty), .auto_en(auto_en),
  .levels_used(levels_used), .thresh(thresh), .base_level_config(base_level_config),
  .mid_level_config(mid_level_config), .high_level_config(high_level_config),
  .raw_a(raw_a), .pwm_out_a(pwm_out_a), .active_level(active_level),
  .coarse_mode(coarse_mode), .limit_event(limit_event));
`default_nettype wire

// ===== tb/pmx_engine_model.sv
// Engine bank model: counters, raw waveforms, window times and comparator.
`timescale 1ns/100ps
`default_nettype none
module pmx_engine_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Overcurrent request per engine
  input wire logic [3:0] trip_en,
  // Engine side
  output var logic [15:0] pwm_count [4],
  output var logic [15:0] blank_start [4],
  output var logic [15:0] blank_end [4],
  output logic [3:0] raw_a,
  output logic [3:0] raw_b,
  output logic [3:0] current_trip_pin
);
  // ****************************************************************
  // Period counter
  // ****************************************************************
  logic [4:0] cnt_q; // Shared 32-cycle period
  logic [4:0] ph [4]; // Phase of each engine
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
  // Unequal widths and phases, so a wrong route or neighbour shows up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ph[i] = cnt_q + 5'(5 * i);
      pwm_count[i] = {11'h000, ph[i]};
      blank_start[i] = 16'(3 + i);
      blank_end[i] = 16'(12 + 2 * i);
      raw_a[i] = ph[i] < 5'(8 + i);
      raw_b[i] = ph[i] >= 5'h10 && ph[i] < 5'(22 + i);
      // Comparator trips one cycle into A and drops with it; four flops of
      // latency cut engine 0 A to five cycles, narrower than its six-cycle B
      current_trip_pin[i] = trip_en[i] && raw_a[i] && ph[i] >= 5'h01;
    end
  end
endmodule // pmx_engine_model
`default_nettype wire

// ===== tb/tb_top.sv
// Testbench of the level switch, edge synthesizer and output combiner.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic sys_clk, sys_rst, auto_en;
  logic [15:0] filter_duty;
  logic [1:0] levels_used;
  pmx_pkg::pmx_thresh_type thresh;
  pmx_pkg::pmx_cfg_type [3:0] base_cfg, mid_cfg;
  pmx_pkg::pmx_edge_ctl_type [3:0] esc;
  logic [15:0] pwm_count [4], blank_start [4], blank_end [4];
  logic [3:0] raw_a, raw_b, trip_pin, trip_en, pwm_out_a, pwm_out_b, coarse_mode, limit_event;
  logic [3:0] ra1, rb1, ra2, rb2, bl, bl1; // Delayed copies for expectations
  logic [2:0] active_level;
  int fails = 0;
  int total_checks = 0;
  // Level table: levels used, duty, expected one-hot level
  localparam int LV_LU [11] = '{2, 2, 2, 2, 2, 2, 2, 1, 2, 0, 2};
  localparam int LV_DUTY [11] = '{200, 250, 150, 50, 450, 350, 250, 450, 50, 450, 100};
  localparam int LV_EXP [11] = '{1, 2, 2, 1, 4, 4, 2, 2, 1, 1, 1};
  pmx_engine_model pmx_engine_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .trip_en(trip_en),
    .pwm_count(pwm_count), .blank_start(blank_start), .blank_end(blank_end), .raw_a(raw_a),
    .raw_b(raw_b), .current_trip_pin(trip_pin));
  pmx_mode_mux pmx_mode_mux_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .filter_duty(filter_duty),
    .auto_en(auto_en), .levels_used(levels_used), .thresh(thresh), .base_level_config(base_cfg),
    .mid_level_config(mid_cfg), .high_level_config(mid_cfg), .edge_synth_control(esc),
    .pwm_count(pwm_count), .blank_start(blank_start), .blank_end(blank_end), .raw_a(raw_a),
    .raw_b(raw_b), .current_trip_pin(trip_pin), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
    .active_level(active_level), .coarse_mode(coarse_mode), .limit_event(limit_event));
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Expected blanking signal and one/two cycle delayed waveforms
  always_ff @(posedge sys_clk) begin
    ra1 <= raw_a;
    rb1 <= raw_b;
    ra2 <= ra1;
    rb2 <= rb1;
    bl1 <= bl;
    for (int i = 0; i < 4; i++) begin
      if (pwm_count[i] == blank_start[i]) begin
        bl[i] <= 1'b1;
      end else if (pwm_count[i] == blank_end[i]) begin
        bl[i] <= 1'b0;
      end
    end
  end
  // Expected output for a combiner code; synth pair picks own/next A/B
  function automatic logic exp_sig(int code, int i, bit isb, int pair, bit en);
    int n;
    n = (i + 1) % 4;
    case (code)
      1: exp_sig = !en ? 1'b0 : pair == 0 ? ra2[i] : pair == 1 ? rb2[i] : pair == 2 ? ra2[n] : rb2[n];
      2: exp_sig = bl1[i];
      3: exp_sig = isb ? ra1[i] : rb1[i];
      4: exp_sig = ra1[n];
      5: exp_sig = rb1[n];
      6, 7, 8: exp_sig = bl1[(i + code - 5) % 4];
      default: exp_sig = isb ? rb1[i] : ra1[i];
    endcase
  endfunction
  // Base set and synth control for all engines; long settle lets stale synth levels clear
  task automatic set_cfg(bit comb, int code, int pair, bit en, bit mb);
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      base_cfg[i] <= '{comb_en: comb, mux_a: 4'(code), mux_b: 4'(code), hires_en: 1'b0,
        match_b: mb};
      esc[i] <= '{en: en, a_rise: 3'(2 * pair), a_fall: 3'(2 * pair + 1), b_rise: 3'(2 * pair),
        b_fall: 3'(2 * pair + 1)};
    end
    repeat (34) @(posedge sys_clk);
  endtask
  // Compare both outputs of every engine over a window
  task automatic check_win(int code, int pair, bit en, int cycles);
    for (int c = 0; c < cycles; c++) begin
      @(negedge sys_clk);
      for (int i = 0; i < 4; i++) begin
        total_checks++;
        if (pwm_out_a[i] !== exp_sig(code, i, 1'b0, pair, en) ||
            pwm_out_b[i] !== exp_sig(code, i, 1'b1, pair, en)) begin
          fails++;
          $display("unexpected at %0t: engine %0d output, code %0d", $time, i, code);
        end
      end
    end
  endtask
  // High cycles of one output over two periods
  task automatic count_hi(int eng, bit isb, int exp);
    int n;
    int m;
    n = 0;
    m = 0;
    repeat (32) @(posedge sys_clk);
    repeat (64) begin
      @(negedge sys_clk);
      if ((isb ? pwm_out_b[eng] : pwm_out_a[eng]) === 1'b1) begin
        n++;
      end
      if (limit_event[eng] === 1'b1) begin
        m++;
      end
    end
    total_checks++;
    if (n != exp) begin
      fails++;
      $display("unexpected at %0t: engine %0d width %0d not %0d", $time, eng, n, exp);
    end
    // One limit pulse per period, on a tripping engine only
    total_checks++;
    if (m != (trip_en[eng] === 1'b1 ? 2 : 0)) begin
      fails++;
      $display("unexpected at %0t: engine %0d limit pulses %0d", $time, eng, m);
    end
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog, well beyond the fewer than two thousand cycles the tests need
  initial begin
    #400000;
    fails++;
    $display("unexpected at %0t: timeout", $time);
    final_report();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    sys_rst = 1'b1;
    auto_en = 1'b0;
    filter_duty = 16'h0000;
    levels_used = 2'h0;
    trip_en = 4'h0;
    thresh = '{low_lower: 16'h0064, low_upper: 16'h00C8, high_lower: 16'h012C,
      high_upper: 16'h0190};
    base_cfg = '0;
    mid_cfg = '0;
    esc = '0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    total_checks++;
    if (pwm_out_a !== 4'h0 || pwm_out_b !== 4'h0 || active_level !== 3'h1) begin
      fails++;
      $display("unexpected at %0t: reset outputs", $time);
    end
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Mid/high sets route crossover, base passes through
    for (int i = 0; i < 4; i++) begin
      mid_cfg[i] <= '{comb_en: 1'b1, mux_a: 4'h3, mux_b: 4'h3, hires_en: 1'b0, match_b: 1'b0};
    end
    auto_en <= 1'b1;
    for (int k = 0; k < 11; k++) begin
      @(posedge sys_clk);
      levels_used <= 2'(LV_LU[k]);
      filter_duty <= 16'(LV_DUTY[k]);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      total_checks++;
      if (active_level !== 3'(LV_EXP[k]) || coarse_mode !== (LV_EXP[k] == 1 ? 4'h0 : 4'hF)) begin
        fails++;
        $display("unexpected at %0t: level step %0d", $time, k);
      end
      if (k == 1) begin
        check_win(3, 0, 1'b1, 40);
      end
    end
    check_win(0, 0, 1'b1, 40);
    $display("test level switching done");
    for (int c = 0; c < 10; c++) begin
      set_cfg(1'b1, c, 0, 1'b1, 1'b0);
      check_win(c, 0, 1'b1, 40);
    end
    set_cfg(1'b0, 5, 0, 1'b1, 1'b0);
    check_win(0, 0, 1'b1, 40);
    $display("test combiner codes done");
    for (int p = 0; p < 4; p++) begin
      set_cfg(1'b1, 1, p, 1'b1, 1'b0);
      check_win(1, p, 1'b1, 40);
    end
    set_cfg(1'b1, 1, 0, 1'b0, 1'b0);
    check_win(1, 0, 1'b0, 40);
    $display("test edge synthesizer done");
    set_cfg(1'b0, 0, 0, 1'b1, 1'b0);
    trip_en <= 4'h1;
    count_hi(0, 1'b0, 10);
    count_hi(1, 1'b0, 18);
    count_hi(0, 1'b1, 12);
    set_cfg(1'b0, 0, 0, 1'b1, 1'b1);
    count_hi(0, 1'b1, 10);
    $display("test pulse truncation done");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
